// ==== rtl/stp_cfg.svh ====
/*
  Constants of the serial test port: instruction codes, widths, reset values.
  Assumes inclusion by bare name from the design files of the test port.
*/
`ifndef STP_CFG_SVH
`define STP_CFG_SVH
`define STP_IR_W 3
`define STP_ID_W 32
`define STP_IR_CAPT 3'h1
`define STP_INS_EXTEST 3'h0
`define STP_INS_IDCODE 3'h1
`define STP_INS_SAMPLE_Z 3'h2
`define STP_INS_SAMPLE 3'h4
`define STP_INS_BYPASS 3'h7
`define STP_PIN_IDLE 1'h1
`endif

// ==== rtl/stp_pkg.sv ====
/*
  Types of the serial test port: the controller state encoding.
  Assumes nothing of its surroundings.
*/
package stp_pkg;
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
    ST_SHF_DR = 16'h0010, ST_EX1_DR = 16'h0020, ST_PAU_DR = 16'h0040, ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100, ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SHF_IR = 16'h0800,
    ST_EX1_IR = 16'h1000, ST_PAU_IR = 16'h2000, ST_EX2_IR = 16'h4000, ST_UPD_IR = 16'h8000
  } stp_state_t;
endpackage : stp_pkg

// ==== rtl/stp_ctl_if.sv ====
/*
  Link between the test-port top and its state machine.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface stp_ctl_if;
  logic rise;
  logic tms;
  stp_pkg::stp_state_t state;
  modport fsm (input rise, input tms, output state);
  modport top (output rise, output tms, input state);
endinterface : stp_ctl_if
`default_nettype wire

// ==== rtl/stp_tap_fsm.sv ====
/*
  Sixteen-state test controller, stepped once per sampled rising test-clock edge.
  Assumes rise is a one-cycle pulse and tms already synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
module stp_tap_fsm (
  // System
  input wire logic clk,
  input wire logic srst,
  // Controller link
  stp_ctl_if.fsm ctl
);
  stp_pkg::stp_state_t state_r;
  stp_pkg::stp_state_t state_nxt;

  assign ctl.state = state_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      stp_pkg::ST_RESET: state_nxt = ctl.tms ? stp_pkg::ST_RESET : stp_pkg::ST_IDLE;
      stp_pkg::ST_IDLE: state_nxt = ctl.tms ? stp_pkg::ST_SEL_DR : stp_pkg::ST_IDLE;
      stp_pkg::ST_SEL_DR: state_nxt = ctl.tms ? stp_pkg::ST_SEL_IR : stp_pkg::ST_CAP_DR;
      stp_pkg::ST_CAP_DR: state_nxt = ctl.tms ? stp_pkg::ST_EX1_DR : stp_pkg::ST_SHF_DR;
      stp_pkg::ST_SHF_DR: state_nxt = ctl.tms ? stp_pkg::ST_EX1_DR : stp_pkg::ST_SHF_DR;
      stp_pkg::ST_EX1_DR: state_nxt = ctl.tms ? stp_pkg::ST_UPD_DR : stp_pkg::ST_PAU_DR;
      stp_pkg::ST_PAU_DR: state_nxt = ctl.tms ? stp_pkg::ST_EX2_DR : stp_pkg::ST_PAU_DR;
      stp_pkg::ST_EX2_DR: state_nxt = ctl.tms ? stp_pkg::ST_UPD_DR : stp_pkg::ST_SHF_DR;
      stp_pkg::ST_UPD_DR: state_nxt = ctl.tms ? stp_pkg::ST_SEL_DR : stp_pkg::ST_IDLE;
      stp_pkg::ST_SEL_IR: state_nxt = ctl.tms ? stp_pkg::ST_RESET : stp_pkg::ST_CAP_IR;
      stp_pkg::ST_CAP_IR: state_nxt = ctl.tms ? stp_pkg::ST_EX1_IR : stp_pkg::ST_SHF_IR;
      stp_pkg::ST_SHF_IR: state_nxt = ctl.tms ? stp_pkg::ST_EX1_IR : stp_pkg::ST_SHF_IR;
      stp_pkg::ST_EX1_IR: state_nxt = ctl.tms ? stp_pkg::ST_UPD_IR : stp_pkg::ST_PAU_IR;
      stp_pkg::ST_PAU_IR: state_nxt = ctl.tms ? stp_pkg::ST_EX2_IR : stp_pkg::ST_PAU_IR;
      stp_pkg::ST_EX2_IR: state_nxt = ctl.tms ? stp_pkg::ST_UPD_IR : stp_pkg::ST_SHF_IR;
      stp_pkg::ST_UPD_IR: state_nxt = ctl.tms ? stp_pkg::ST_SEL_DR : stp_pkg::ST_IDLE;
      default: state_nxt = stp_pkg::ST_RESET;
    endcase
  end

  // Steps only on a sampled rising edge of the test clock
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= stp_pkg::ST_RESET;
    end else if (ctl.rise) begin
      state_r <= state_nxt;
    end
  end
endmodule : stp_tap_fsm
`default_nettype wire

// ==== rtl/stp_tap_port.sv ====
/*
  Serial boundary-scan test port: pin sampling, instruction, bypass and
  identification registers, serial output. Boundary register lives outside.
  Assumes tck, tms, tdi are asynchronous pins with pad pull-ups on tms and
  tdi, and clk at least four times faster than tck.
*/
`timescale 1ns/1ps
`default_nettype none
`include "stp_cfg.svh"
module stp_tap_port #(
  parameter logic [`STP_ID_W-1:0] ID_CODE = 32'h0000_0001 // Arbitrary value, bit 0 set
) (
  // System
  input wire logic clk,
  input wire logic srst,
  // Test pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // Boundary register hook
  output logic bsr_sel,
  output logic bsr_capture,
  output logic bsr_shift,
  output logic bsr_update,
  output logic bsr_si,
  input wire logic bsr_so,
  // Current instruction
  output logic [`STP_IR_W-1:0] ins
);
  initial begin
    if (ID_CODE[0] != 1'b1) $error("ID_CODE bit 0 must be one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detect
  logic [1:0] tck_s_r;
  logic tck_d_r;
  logic [1:0] tms_s_r;
  logic [1:0] tdi_s_r;
  logic rise;
  logic fall;

  always_ff @(posedge clk) begin
    if (srst) begin
      tck_s_r <= 2'h0;
      tck_d_r <= 1'h0;
      tms_s_r <= {2{`STP_PIN_IDLE}};
      tdi_s_r <= {2{`STP_PIN_IDLE}};
    end else begin
      tck_s_r <= {tck_s_r[0], tck};
      tck_d_r <= tck_s_r[1];
      tms_s_r <= {tms_s_r[0], tms};
      tdi_s_r <= {tdi_s_r[0], tdi};
    end
  end

  // A stopped tck leaves both pulses low, so nothing past the pin synchronisers moves
  assign rise = tck_s_r[1] & ~tck_d_r;
  assign fall = ~tck_s_r[1] & tck_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Controller
  stp_ctl_if ctl ();
  stp_pkg::stp_state_t st;

  assign ctl.rise = rise;
  assign ctl.tms = tms_s_r[1];
  assign st = ctl.state;

  stp_tap_fsm u_fsm (
    .clk(clk),
    .srst(srst),
    .ctl(ctl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register
  logic [`STP_IR_W-1:0] ir_sh_r;
  logic [`STP_IR_W-1:0] ir_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      ir_sh_r <= `STP_INS_IDCODE;
    end else if (rise) begin
      if (st == stp_pkg::ST_CAP_IR) begin
        ir_sh_r <= `STP_IR_CAPT;
      end else if (st == stp_pkg::ST_SHF_IR) begin
        ir_sh_r <= {tdi_s_r[1], ir_sh_r[`STP_IR_W-1:1]};
      end
    end
  end

  // Only test-port state is touched
  always_ff @(posedge clk) begin
    if (srst) begin
      ir_r <= `STP_INS_IDCODE;
    end else if (st == stp_pkg::ST_RESET) begin
      // Loaded as soon as reset is entered, not at the next test-clock rise
      ir_r <= `STP_INS_IDCODE;
    end else if (rise && st == stp_pkg::ST_UPD_IR) begin
      ir_r <= ir_sh_r;
    end
  end

  assign ins = ir_r;

  ////////////////////////////////////////////////////////////////////////////
  // Data registers
  logic sel_id;
  logic sel_bsr;
  logic byp_r;
  logic [`STP_ID_W-1:0] id_r;

  assign sel_id = ir_r == `STP_INS_IDCODE;
  assign sel_bsr = ir_r == `STP_INS_EXTEST || ir_r == `STP_INS_SAMPLE ||
                   ir_r == `STP_INS_SAMPLE_Z;

  // Reserved codes fall back to bypass
  always_ff @(posedge clk) begin
    if (srst) begin
      byp_r <= 1'h0;
    end else if (rise && !sel_id && !sel_bsr) begin
      if (st == stp_pkg::ST_CAP_DR) begin
        byp_r <= 1'h0;
      end else if (st == stp_pkg::ST_SHF_DR) begin
        byp_r <= tdi_s_r[1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      id_r <= ID_CODE;
    end else if (rise && sel_id) begin
      if (st == stp_pkg::ST_CAP_DR) begin
        id_r <= ID_CODE;
      end else if (st == stp_pkg::ST_SHF_DR) begin
        id_r <= {tdi_s_r[1], id_r[`STP_ID_W-1:1]};
      end
    end
  end

  assign bsr_sel = sel_bsr;
  assign bsr_si = tdi_s_r[1];
  assign bsr_capture = rise && sel_bsr && st == stp_pkg::ST_CAP_DR;
  assign bsr_shift = rise && sel_bsr && st == stp_pkg::ST_SHF_DR;
  assign bsr_update = rise && sel_bsr && st == stp_pkg::ST_UPD_DR;

  ////////////////////////////////////////////////////////////////////////////
  // Serial output, moved on the falling edge
  logic tdo_bit;

  always_comb begin
    if (st == stp_pkg::ST_SHF_IR) begin
      tdo_bit = ir_sh_r[0];
    end else if (sel_id) begin
      tdo_bit = id_r[0];
    end else if (sel_bsr) begin
      tdo_bit = bsr_so;
    end else begin
      tdo_bit = byp_r;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tdo <= 1'h0;
      tdo_oe <= 1'h0;
    end else if (fall) begin
      tdo <= tdo_bit;
      tdo_oe <= st == stp_pkg::ST_SHF_IR || st == stp_pkg::ST_SHF_DR;
    end
  end
endmodule : stp_tap_port
`default_nettype wire

// ==== testbench/stp_tap_sva.sv ====
/* Assertions on the test port pins and boundary hook.
   Assumes a bind onto stp_tap_port. */
`timescale 1ns/1ps
`default_nettype none
module stp_tap_sva (
  // System
  input wire logic clk,
  input wire logic srst,
  // Pins and hook
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic bsr_sel,
  input wire logic bsr_shift,
  input wire logic bsr_si,
  input wire logic [2:0] ins
);
  logic [2:0] ones_r;
  // Test-clock rises in a row with mode select high
  always_ff @(posedge clk) begin
    if (srst) ones_r <= 3'h0;
    else if ($rose(tck)) ones_r <= !tms ? 3'h0 : ones_r == 3'h5 ? 3'h5 : ones_r + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_RST: assert property (disable iff (1'b0) srst |=> !tdo_oe && ins == 3'h1)
    else $error("reset");
  AST_TDO: assert property (tck [*4] |-> $stable(tdo)) else $error("tdo");
  AST_OE: assert property ($changed(tdo_oe) && !$past(srst) |-> !tck && !$past(tck))
    else $error("tdo_oe");
  AST_SEL: assert property (bsr_shift |-> bsr_sel) else $error("sel");
  AST_RISE: assert property (bsr_shift |-> tck && !$past(tck, 8)) else $error("rise");
  AST_SI: assert property (bsr_shift |-> bsr_si == tdi) else $error("si");
  AST_TRST: assert property ($rose(ones_r == 3'h5) |-> ##[1:8] ins == 3'h1)
    else $error("test reset");
  AST_INS: assert property ($changed(ins) && !$past(srst) |-> tck) else $error("ins");
  COV_SHIFT: cover property (bsr_shift);
  COV_OE: cover property ($rose(tdo_oe));
  COV_BYP: cover property (ins == 3'h7);
endmodule : stp_tap_sva
bind stp_tap_port stp_tap_sva u_sva (.clk, .srst, .tck, .tms, .tdi, .tdo, .tdo_oe,
  .bsr_sel, .bsr_shift, .bsr_si, .ins);
`default_nettype wire

// ==== testbench/stp_scan_master.sv ====
/* Model of the scan controller that drives the test pins.
   Assumes the port samples pins on test-clock rises. */
`timescale 1ns/1ps
`default_nettype none
module stp_scan_master (
  // Test pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial {tck, tms, tdi} = 3'b011;
  // One period: pins set while low, tdo taken just before the rise
  task automatic step(logic m, logic v, output logic o);
    tms = m;
    tdi = v;
    #80 o = tdo;
    tck = 1'b1;
    #80 tck = 1'b0;
  endtask : step
endmodule : stp_scan_master
`default_nettype wire

// ==== testbench/tb.sv ====
/* Self-checking bench of the serial test port.
   Assumes the controller model owns the test pins. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [31:0] ID_P = 32'h0a5c_3e01; // Arbitrary value, bit 0 set
  logic clk = 1'b0, srst = 1'b1, bsr_so = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, q, bsr_sel, bsr_capture, bsr_shift, bsr_update, bsr_si;
  logic [2:0] ins, c;
  logic [31:0] d, got;
  int failures = 0, cmp_count = 0;
  int n_cap = 0, n_sh = 0, n_upd = 0, b_cap, b_sh, b_upd;
  stp_scan_master u_ctl (.tck, .tms, .tdi, .tdo);
  stp_tap_port #(.ID_CODE(ID_P)) u_dut (.clk, .srst, .tck, .tms, .tdi, .tdo, .tdo_oe,
    .bsr_sel, .bsr_capture, .bsr_shift, .bsr_update, .bsr_si, .bsr_so, .ins);
  initial forever #2 clk = ~clk;
  // Boundary hook pulses, counted as they stand for one clock
  always @(posedge clk) begin
    n_cap += int'(bsr_capture);
    n_sh += int'(bsr_shift);
    n_upd += int'(bsr_update);
  end
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(string n, logic [31:0] e, logic [31:0] a);
    cmp_count++;
    if (a !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, a);
    end
  endtask : chk
  function automatic logic [31:0] exp_dr(logic [2:0] k, logic [31:0] v, logic b);
    return k == 3'h1 ? ID_P : k inside {3'h0, 3'h2, 3'h4} ? {32{b}} : {v[30:0], 1'b0};
  endfunction : exp_dr
  // Idle to shift, n bits LSB first, then update and back to idle
  task automatic scan(logic ir, int n, logic [31:0] v, output logic [31:0] o);
    logic oe = 1'b1;
    o = '0;
    repeat (ir ? 2 : 1) u_ctl.step(1'b1, 1'b1, q);
    repeat (2) u_ctl.step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      u_ctl.step(i == n - 1, v[i], o[i]);
      oe &= tdo_oe;
    end
    u_ctl.step(1'b1, 1'b1, q);
    u_ctl.step(1'b0, 1'b1, q);
    chk("tdo_oe", 32'h1, {31'h0, oe});
  endtask : scan
  initial begin
    #300000 chk("timeout", 32'h0, 32'h1);
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h0ccc0132));
    repeat (3) @(posedge clk);
    @(negedge clk) srst = 1'b0;
    chk("tdo_oe", 32'h0, {31'h0, tdo_oe});
    chk("ins", 32'h1, {29'h0, ins});
    u_ctl.step(1'b0, 1'b1, q);
    scan(1'b0, 32, $urandom(), got);
    chk("id", ID_P, got);
    for (int k = 23; k >= 0; k--) begin
      c = k < 8 ? k[2:0] : 3'($urandom_range(7, 0));
      scan(1'b1, 3, {29'h0, c}, got);
      chk("ir capture", 32'h1, got);
      chk("ins", {29'h0, c}, {29'h0, ins});
      chk("bsr_sel", {31'h0, c inside {3'h0, 3'h2, 3'h4}}, {31'h0, bsr_sel});
      bsr_so = 1'($urandom());
      d = $urandom();
      b_cap = n_cap;
      b_sh = n_sh;
      b_upd = n_upd;
      scan(1'b0, 32, d, got);
      chk("dr", exp_dr(c, d, bsr_so), got);
      chk("bsr_capture", c inside {3'h0, 3'h2, 3'h4} ? 32'h1 : 32'h0, n_cap - b_cap);
      chk("bsr_shift", c inside {3'h0, 3'h2, 3'h4} ? 32'h20 : 32'h0, n_sh - b_sh);
      chk("bsr_update", c inside {3'h0, 3'h2, 3'h4} ? 32'h1 : 32'h0, n_upd - b_upd);
    end
    u_ctl.step(1'b1, 1'b1, q);
    repeat (3) u_ctl.step(1'b0, 1'b1, q);
    repeat (5) u_ctl.step(1'b1, 1'b1, q);
    chk("ins reset", 32'h1, {29'h0, ins});
    chk("tdo_oe reset", 32'h0, {31'h0, tdo_oe});
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
